// File: common/msdp_pkg.sv
package msdp_pkg;
   // ----------------------------------------------------------------
   // serial timing
   // ----------------------------------------------------------------
   localparam int BAUD_DIV = 256;
   localparam int BUS_PER_CLK = 1;
   localparam int BIT_CYCLES = BAUD_DIV * BUS_PER_CLK;
   localparam int HALF_CYCLES = BIT_CYCLES / 2;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYCLES - 1);
   localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYCLES - 1);
   localparam int TURN_BITS = 2;
   localparam int BREAK_BITS = 10;
   localparam int FRAME_BITS = 10;
   localparam logic [3:0] BYTE_TX_BITS = 4'(TURN_BITS + FRAME_BITS);
   localparam logic [3:0] BRK_TX_BITS = 4'(TURN_BITS + BREAK_BITS + 1);
   localparam logic [2:0] DATA_LAST = 3'h7;
   // ----------------------------------------------------------------
   // data path and security
   // ----------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int SEC_BYTES = 8;
   localparam logic [2:0] SEC_LAST = 3'(SEC_BYTES - 1);
   localparam logic [7:0] EXT_LOCK_VALUE = 8'h00;
   localparam logic [15:0] STATUS_ADDR = 16'h0080;
   localparam int STATUS_BIT = 6;
   localparam logic [15:0] FLASH_LO = 16'h8000;
   localparam logic [15:0] FLASH_HI = 16'hffff;
   localparam logic [7:0] INVALID_DATA = 8'h00;
   localparam int PAGE_SHIFT = 6;
   localparam logic [15:0] BLOCK_PROTECT_ADDR = 16'hff7e;
   localparam logic [15:0] SP_OFFSET = 16'h0001;
   // ----------------------------------------------------------------
   // command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_READ = 8'h01;
   localparam logic [7:0] OP_WRITE = 8'h02;
   localparam logic [7:0] OP_INDEXED_READ = 8'h03;
   localparam logic [7:0] OP_INDEXED_WRITE = 8'h04;
   localparam logic [7:0] OP_STACK_READ = 8'h05;
   localparam logic [7:0] OP_RUN = 8'h06;
   localparam logic [1:0] READ_ARGS = 2'h2;
   localparam logic [1:0] WRITE_ARGS = 2'h3;
   localparam logic [1:0] INDEXED_WRITE_ARGS = 2'h1;
   localparam logic [1:0] ARG_DATA = 2'h2;

   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_HOLD} msdp_rx_t;
   typedef enum logic [3:0] {
      M_WAIT, M_ECHO, M_PROC, M_EXEC, M_RDW, M_RD, M_SEND, M_BRK, M_REFUSED
   } msdp_main_t;
endpackage

// File: common/msdp_stream_if.sv
`timescale 1ns/10ps
interface msdp_stream_if #(parameter int W = 8);
   logic push_valid;
   logic push_ready;
   logic [W-1:0] push_data;
   logic pop_valid;
   logic pop_ready;
   logic [W-1:0] pop_data;
   modport store (input push_valid, input push_data, input pop_ready,
                  output push_ready, output pop_valid, output pop_data);
   modport user (output push_valid, output push_data, output pop_ready,
                 input push_ready, input pop_valid, input pop_data);
endinterface

// File: verilog/msdp_fifo.sv
`timescale 1ns/10ps
module msdp_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   input wire logic clk,    // bus clock
   input wire logic resetn, // power-on reset, low active
   msdp_stream_if.store s   // push and pop sides
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic full;
   logic empty;

   assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign empty = (wr_ptr == rd_ptr);
   assign s.push_ready = !full;
   assign s.pop_valid = !empty;
   assign s.pop_data = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (s.push_valid && !full) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (s.pop_ready && !empty) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (s.push_valid && !full) begin
         mem[wr_ptr[AW-1:0]] <= s.push_data;
      end
   end
endmodule // msdp_fifo

// File: verilog/msdp_monitor.sv
`timescale 1ns/10ps
// Operation
// - break is ten consecutive low bit times: start bit plus nine more
// - on a break once the security check is done, drive the line high two bits then send a break back
// - bit time is the bus clock divided by 256
// - every received byte is echoed back on the same pin
// - two-bit turnaround before each echo and before returned read data
// - read data goes out only after the last command byte is echoed
// - six commands: read, write, indexed read/write, stack read, run
// - run asks the core to pop index high and return from interrupt
// - stack read returns stack pointer plus one
// - after power-on, eight security bytes are compared to stored code
// - a good match survives all resets except power-on
// - on mismatch flash reads are invalid, flash execution forces reset
// - ready break only after all eight security bytes arrived
// - status bit 6 at address 0x80 shows security passed
// - mass erase blanks the security bytes to all ones
// - lock byte of zero refuses monitor even with matching code
// - lock released only by failed check followed by mass erase
// - erase takes a 64-byte page, or whole array at block protect address
// - both ends use NRZ framing at one common baud rate
module msdp_monitor (
   input wire logic clk,                 // bus clock
   input wire logic resetn,              // power-on reset, low active
   input wire logic sys_reset_n,         // any other reset, low active
   input wire logic pin_in,              // monitor_serial_pin level
   output logic pin_out,                 // monitor_serial_pin drive value
   output logic pin_oe,                  // monitor_serial_pin drive enable
   input wire logic [63:0] sec_code,     // stored security bytes, first in low byte
   input wire logic [7:0] ext_lock_byte, // lock byte from flash
   input wire logic [15:0] stack_ptr,    // core stack pointer
   output logic [15:0] mem_addr,         // memory address
   output logic [7:0] mem_wdata,         // memory write data
   output logic mem_wr,                  // memory write strobe
   output logic mem_rd,                  // memory read strobe
   input wire logic [7:0] mem_rdata,     // read data, cycle after mem_rd
   input wire logic exec_flash_fetch,    // core fetches code from flash
   output logic illegal_addr_reset,      // request illegal address reset
   output logic run_req,                 // run user program request
   output logic secure,                  // security check passed
   output logic monitor_refused,         // monitor entry refused by lock
   input wire logic erase_req,           // erase routine request
   input wire logic [15:0] erase_addr,   // erase target address
   output logic erase_page_go,           // erase one page
   output logic [15:0] erase_page_base,  // first address of page
   output logic mass_erase_go            // erase whole array
);
   import msdp_pkg::*;

   msdp_stream_if #(.W(DATA_W)) rxq ();

   msdp_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .resetn(resetn),
      .s(rxq.store)
   );

   logic pin_s1;
   logic pin_s2;
   msdp_rx_t rx_state;
   logic [CNT_W-1:0] rx_cnt;
   logic [2:0] rx_bit;
   logic [7:0] rx_sh;
   logic rx_break;
   logic tx_busy;
   logic tx_done;
   logic [CNT_W-1:0] tx_cnt;
   logic [3:0] tx_left;
   logic [12:0] tx_sh;
   logic tx_start;
   logic tx_brk;
   logic [7:0] tx_data;
   logic brk_pending;
   logic brk_take;
   msdp_main_t m_state;
   logic [7:0] cur_byte;
   logic [7:0] cmd;
   logic [1:0] arg_left;
   logic [1:0] arg_idx;
   logic [15:0] addr;
   logic [7:0] wdata;
   logic [2:0] sec_idx;
   logic sec_match;
   logic sec_done;
   logic sp_low;
   logic all_ok;
   logic [15:0] sp_plus;

   // ----------------------------------------------------------------
   // read data filter
   // ----------------------------------------------------------------
   function automatic logic [7:0] read_filter(input logic [15:0] a, input logic [7:0] d,
                                              input logic ok);
      logic [7:0] r;
      r = d;
      if (a == STATUS_ADDR) begin
         r[STATUS_BIT] = ok;
      end else if (a >= FLASH_LO && a <= FLASH_HI && !ok) begin
         r = INVALID_DATA;
      end
      return r;
   endfunction

   assign all_ok = sec_match && (cur_byte == sec_code[sec_idx*8 +: 8]);
   assign sp_plus = stack_ptr + SP_OFFSET;
   assign brk_take = (m_state == M_WAIT) && brk_pending;
   assign rxq.pop_ready = (m_state == M_WAIT) && !brk_pending;

   // ----------------------------------------------------------------
   // pin synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pin_s1 <= 1'b1;
         pin_s2 <= 1'b1;
      end else begin
         pin_s1 <= pin_in;
         pin_s2 <= pin_s1;
      end
   end

   // ----------------------------------------------------------------
   // receiver, sampling at mid bit; idle while transmitting
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rx_state <= RX_IDLE;
         rx_cnt <= '0;
         rx_bit <= '0;
         rx_sh <= '0;
         rx_break <= 1'b0;
         rxq.push_valid <= 1'b0;
         rxq.push_data <= '0;
      end else begin
         rx_break <= 1'b0;
         rxq.push_valid <= 1'b0;
         rx_cnt <= rx_cnt + 1'b1;
         unique case (rx_state)
            RX_IDLE: begin
               rx_cnt <= '0;
               // a full queue holds off the next frame
               if (!tx_busy && !pin_s2 && rxq.push_ready) begin
                  rx_state <= RX_START;
               end
            end
            RX_START: begin
               if (rx_cnt == HALF_LAST) begin
                  rx_cnt <= '0;
                  rx_bit <= '0;
                  rx_state <= pin_s2 ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (rx_cnt == BIT_LAST) begin
                  rx_cnt <= '0;
                  rx_sh <= {pin_s2, rx_sh[7:1]};
                  rx_bit <= rx_bit + 1'b1;
                  if (rx_bit == DATA_LAST) begin
                     rx_state <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (rx_cnt == BIT_LAST) begin
                  rx_cnt <= '0;
                  if (pin_s2) begin
                     rxq.push_valid <= 1'b1;
                     rxq.push_data <= rx_sh;
                     rx_state <= RX_IDLE;
                  end else begin
                     // tenth low bit with all-zero data is a break
                     rx_break <= (rx_sh == 8'h00);
                     rx_state <= RX_HOLD;
                  end
               end
            end
            RX_HOLD: begin
               if (pin_s2) begin
                  rx_state <= RX_IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // transmitter: two high turnaround bits, then frame or break
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tx_busy <= 1'b0;
         tx_done <= 1'b0;
         tx_cnt <= '0;
         tx_left <= '0;
         tx_sh <= '0;
         pin_out <= 1'b1;
         pin_oe <= 1'b0;
      end else begin
         tx_done <= 1'b0;
         if (!tx_busy) begin
            if (tx_start) begin
               tx_busy <= 1'b1;
               tx_cnt <= '0;
               pin_oe <= 1'b1;
               pin_out <= 1'b1;
               if (tx_brk) begin
                  tx_sh <= {1'b1, 10'h000, 2'b11};
                  tx_left <= BRK_TX_BITS;
               end else begin
                  tx_sh <= {2'b01, tx_data, 1'b0, 2'b11};
                  tx_left <= BYTE_TX_BITS;
               end
            end
         end else if (tx_cnt == BIT_LAST) begin
            tx_cnt <= '0;
            if (tx_left == 4'h1) begin
               tx_busy <= 1'b0;
               tx_done <= 1'b1;
               pin_oe <= 1'b0;
               pin_out <= 1'b1;
            end else begin
               tx_left <= tx_left - 1'b1;
               tx_sh <= {1'b0, tx_sh[12:1]};
               pin_out <= tx_sh[1];
            end
         end else begin
            tx_cnt <= tx_cnt + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // break pending flag, a new break wins over the clear
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         brk_pending <= 1'b0;
      end else begin
         brk_pending <= rx_break || (brk_pending && !brk_take);
      end
   end

   // ----------------------------------------------------------------
   // command sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         m_state <= M_WAIT;
         cur_byte <= '0;
         cmd <= '0;
         arg_left <= '0;
         arg_idx <= '0;
         addr <= '0;
         wdata <= '0;
         sec_idx <= '0;
         sec_match <= 1'b1;
         sec_done <= 1'b0;
         secure <= 1'b0;
         monitor_refused <= 1'b0;
         sp_low <= 1'b0;
         tx_start <= 1'b0;
         tx_brk <= 1'b0;
         tx_data <= '0;
         mem_addr <= '0;
         mem_wdata <= '0;
         mem_wr <= 1'b0;
         mem_rd <= 1'b0;
         run_req <= 1'b0;
      end else begin
         tx_start <= 1'b0;
         mem_wr <= 1'b0;
         mem_rd <= 1'b0;
         run_req <= 1'b0;
         if (!sys_reset_n) begin
            // security result is kept; only a passed check skips entry
            m_state <= M_WAIT;
            arg_left <= '0;
            sp_low <= 1'b0;
            sec_done <= secure;
            sec_idx <= '0;
            sec_match <= 1'b1;
         end else begin
            unique case (m_state)
               M_WAIT: begin
                  if (brk_take) begin
                     arg_left <= '0;
                     if (sec_done && !monitor_refused) begin
                        tx_brk <= 1'b1;
                        tx_start <= 1'b1;
                        m_state <= M_BRK;
                     end
                  end else if (rxq.pop_valid) begin
                     cur_byte <= rxq.pop_data;
                     tx_data <= rxq.pop_data;
                     tx_brk <= 1'b0;
                     tx_start <= 1'b1;
                     m_state <= M_ECHO;
                  end
               end
               M_ECHO: begin
                  if (tx_done) begin
                     m_state <= M_PROC;
                  end
               end
               M_PROC: begin
                  if (!sec_done) begin
                     sec_match <= all_ok;
                     sec_idx <= sec_idx + 1'b1;
                     m_state <= M_WAIT;
                     if (sec_idx == SEC_LAST) begin
                        sec_done <= 1'b1;
                        if (all_ok && ext_lock_byte == EXT_LOCK_VALUE) begin
                           monitor_refused <= 1'b1;
                           m_state <= M_REFUSED;
                        end else begin
                           secure <= all_ok;
                           tx_brk <= 1'b1;
                           tx_start <= 1'b1;
                           m_state <= M_BRK;
                        end
                     end
                  end else if (arg_left == 2'h0) begin
                     cmd <= cur_byte;
                     m_state <= M_WAIT;
                     case (cur_byte)
                        OP_READ: begin
                           arg_left <= READ_ARGS;
                           arg_idx <= '0;
                        end
                        OP_WRITE: begin
                           arg_left <= WRITE_ARGS;
                           arg_idx <= '0;
                        end
                        OP_INDEXED_WRITE: begin
                           arg_left <= INDEXED_WRITE_ARGS;
                           arg_idx <= ARG_DATA;
                        end
                        OP_INDEXED_READ, OP_STACK_READ, OP_RUN: m_state <= M_EXEC;
                        default: m_state <= M_WAIT;
                     endcase
                  end else begin
                     unique case (arg_idx)
                        2'h0: addr[15:8] <= cur_byte;
                        2'h1: addr[7:0] <= cur_byte;
                        default: wdata <= cur_byte;
                     endcase
                     arg_idx <= arg_idx + 1'b1;
                     arg_left <= arg_left - 1'b1;
                     m_state <= (arg_left == 2'h1) ? M_EXEC : M_WAIT;
                  end
               end
               M_EXEC: begin
                  m_state <= M_WAIT;
                  case (cmd)
                     OP_READ, OP_INDEXED_READ: begin
                        mem_rd <= 1'b1;
                        mem_addr <= addr;
                        m_state <= M_RDW;
                     end
                     OP_WRITE, OP_INDEXED_WRITE: begin
                        mem_wr <= 1'b1;
                        mem_addr <= addr;
                        mem_wdata <= wdata;
                        addr <= addr + 1'b1;
                     end
                     OP_STACK_READ: begin
                        tx_brk <= 1'b0;
                        tx_data <= sp_plus[15:8];
                        tx_start <= 1'b1;
                        sp_low <= 1'b1;
                        m_state <= M_SEND;
                     end
                     OP_RUN: run_req <= 1'b1;
                     default: m_state <= M_WAIT;
                  endcase
               end
               M_RDW: m_state <= M_RD;
               M_RD: begin
                  tx_brk <= 1'b0;
                  tx_data <= read_filter(mem_addr, mem_rdata, secure);
                  tx_start <= 1'b1;
                  addr <= addr + 1'b1;
                  m_state <= M_SEND;
               end
               M_SEND: begin
                  if (tx_done) begin
                     if (sp_low) begin
                        tx_data <= sp_plus[7:0];
                        tx_start <= 1'b1;
                        sp_low <= 1'b0;
                     end else begin
                        m_state <= M_WAIT;
                     end
                  end
               end
               M_BRK: begin
                  if (tx_done) begin
                     m_state <= M_WAIT;
                  end
               end
               M_REFUSED: m_state <= M_REFUSED;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // flash execution guard
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         illegal_addr_reset <= 1'b0;
      end else begin
         illegal_addr_reset <= exec_flash_fetch && !secure;
      end
   end

   // ----------------------------------------------------------------
   // erase request decode; the array blanks the security bytes
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         erase_page_go <= 1'b0;
         mass_erase_go <= 1'b0;
         erase_page_base <= '0;
      end else begin
         erase_page_go <= erase_req && (erase_addr != BLOCK_PROTECT_ADDR);
         mass_erase_go <= erase_req && (erase_addr == BLOCK_PROTECT_ADDR);
         if (erase_req) begin
            erase_page_base <= {erase_addr[15:PAGE_SHIFT], PAGE_SHIFT'(0)};
         end
      end
   end
endmodule // msdp_monitor

// File: tb/msdp_chk_monitor.sv
`timescale 1ns/10ps
module msdp_chk (
   input wire logic clk, // bus clock
   input wire logic resetn, // power-on reset
   input wire logic sys_reset_n, // other reset
   input wire logic pin_out, // pin value
   input wire logic pin_oe, // pin enable
   input wire logic mem_rd, // read strobe
   input wire logic exec_flash_fetch, // flash fetch
   input wire logic illegal_addr_reset, // reset request
   input wire logic secure, // check passed
   input wire logic erase_req, // erase request
   input wire logic [15:0] erase_addr, // erase target
   input wire logic erase_page_go, // page erase
   input wire logic [15:0] erase_page_base, // page base
   input wire logic mass_erase_go // array erase
);
   import msdp_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   logic [11:0] cnt;
   // cycles since the pin drive started
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) cnt <= 12'h000;
      else if (pin_oe) cnt <= cnt + 12'h001;
      else cnt <= 12'h000;
   end
   a_lead_high: assert property (pin_oe && cnt < 12'h200 |-> pin_out)
      else $error("lead low");
   a_start_low: assert property (pin_oe && cnt >= 12'h200 &&
      cnt < 12'h300 |-> !pin_out) else $error("start bit high");
   a_frame_span: assert property ($fell(pin_oe) |-> cnt == 12'hc00 || cnt == 12'hd00)
      else $error("frame length");
   a_erase_page: assert property (erase_req && erase_addr != BLOCK_PROTECT_ADDR |=>
      erase_page_go && !mass_erase_go && erase_page_base == {$past(erase_addr[15:6]), 6'h00})
      else $error("page erase");
   a_erase_mass: assert property (erase_req && erase_addr == BLOCK_PROTECT_ADDR |=>
      mass_erase_go && !erase_page_go) else $error("mass erase");
   a_erase_idle: assert property (!erase_req |=> !erase_page_go && !mass_erase_go)
      else $error("erase without request");
   a_illegal_fetch: assert property (exec_flash_fetch && !secure
      |=> illegal_addr_reset) else $error("no illegal reset");
   a_secure_kept: assert property (!sys_reset_n && secure |=> secure)
      else $error("security lost");
   c_secure: cover property ($rose(secure));
   c_mass: cover property (mass_erase_go);
   c_read: cover property (mem_rd);
endmodule // msdp_chk

// File: tb/msdp_host.sv
`timescale 1ns/10ps
module msdp_host (
   input wire logic clk, // bus clock
   input wire logic line, // resolved pin level
   input wire logic dev_oe, // device drives pin
   output logic pull_low // host pulls pin low
);
   int stalls = 0;
   initial pull_low = 1'b0;
   // frame bits lsb first, line released after
   task automatic send(input logic [9:0] f);
      for (int i = 0; i < 10; i++) begin
         pull_low = !f[i];
         repeat (256) @(negedge clk);
      end
      pull_low = 1'b0;
   endtask
   // returns {stop, data}; all zero for a break
   task automatic get(output logic [8:0] v);
      int t;
      v = 9'h1ff;
      t = 0;
      while (line !== 1'b0 && t < 4000) begin
         @(negedge clk);
         t++;
      end
      if (t >= 4000) stalls++;
      repeat (128) @(negedge clk);
      for (int i = 0; i < 9; i++) begin
         repeat (256) @(negedge clk);
         v[i] = line;
      end
      t = 0;
      while (dev_oe !== 1'b0 && t < 4000) begin
         @(negedge clk);
         t++;
      end
      if (t >= 4000) stalls++;
      repeat (256) @(negedge clk);
   endtask
endmodule // msdp_host

// File: tb/msdp_monitor_test.sv
`timescale 1ns/10ps
module msdp_monitor_test;
   import msdp_pkg::*;
   typedef struct {logic [15:0] a; logic pg; logic ms;} msdp_row_t;
   msdp_row_t rows [3] = '{'{16'h8043, 1'b1, 1'b0}, '{16'hff7e, 1'b0, 1'b1},
      '{16'hffbf, 1'b1, 1'b0}};
   logic clk = 1'b0, resetn = 1'b0, sys_reset_n = 1'b1, exec_flash_fetch = 1'b0;
   logic erase_req = 1'b0, pull_low, pin_out, pin_oe, mem_wr, mem_rd, illegal_addr_reset;
   logic run_req, secure, monitor_refused, erase_page_go, mass_erase_go;
   logic [63:0] sec_code = 64'h0817_2635_4453_6271;
   logic [7:0] ext_lock_byte = 8'h5a, mem_rdata = 8'h00, mem_wdata;
   logic [15:0] stack_ptr = 16'h12ff, erase_addr = 16'h0000, mem_addr, erase_page_base;
   logic [8:0] v;
   wire logic line = pin_oe ? pin_out : !pull_low;
   int error_cnt = 0, comparisons = 0;
   int runs = 0;
   always #2 clk = !clk;
   msdp_monitor dut (.*, .pin_in(line));
   msdp_host host (.clk(clk), .line(line), .dev_oe(pin_oe), .pull_low(pull_low));
   // memory answers the cycle after a read strobe
   always @(negedge clk) if (mem_rd === 1'b1) mem_rdata <= mem_addr[7:0] + 8'h21;
   always @(negedge clk) if (run_req === 1'b1) runs++;
   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic xfer(input logic [7:0] b);
      host.send({1'b1, b, 1'b0});
      host.get(v);
      cmp("echo", {7'h00, 1'b1, b}, {7'h00, v});
   endtask
   task automatic give_verdict;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (98000) @(posedge clk);
      error_cnt++;
      give_verdict();
   end
   // ----
   // main sequence
   // ----
   initial begin
      repeat (5) @(negedge clk);
      cmp("oe in reset", 16'h0000, {15'h0000, pin_oe});
      resetn = 1'b1;
      exec_flash_fetch = 1'b1;
      @(negedge clk);
      exec_flash_fetch = 1'b0;
      cmp("illegal reset", 16'h0001, {15'h0000, illegal_addr_reset});
      foreach (rows[i]) begin
         erase_addr = rows[i].a;
         erase_req = 1'b1;
         @(negedge clk);
         erase_req = 1'b0;
         cmp("page go", {15'h0000, rows[i].pg}, {15'h0000, erase_page_go});
         cmp("mass go", {15'h0000, rows[i].ms}, {15'h0000, mass_erase_go});
         if (rows[i].pg) cmp("page base", rows[i].a & 16'hffc0, erase_page_base);
         @(negedge clk);
      end
      for (int k = 0; k < SEC_BYTES; k++) xfer(sec_code[8*k +: 8]);
      host.get(v);
      cmp("ready break", 16'h0000, {7'h00, v});
      cmp("secure", 16'h0001, {15'h0000, secure});
      xfer(OP_READ);
      xfer(8'h00);
      xfer(8'h80);
      host.get(v);
      cmp("read data", 16'h01e1, {7'h00, v});
      xfer(OP_STACK_READ);
      host.get(v);
      cmp("sp high", 16'h0113, {7'h00, v});
      host.get(v);
      cmp("sp low", 16'h0100, {7'h00, v});
      sys_reset_n = 1'b0;
      @(negedge clk);
      sys_reset_n = 1'b1;
      @(negedge clk);
      cmp("secure kept", 16'h0001, {15'h0000, secure});
      xfer(OP_RUN);
      cmp("run pulses", 16'h0001, 16'(runs));
      cmp("refused", 16'h0000, {15'h0000, monitor_refused});
      cmp("host stalls", 16'h0000, 16'(host.stalls));
      give_verdict();
   end
endmodule // msdp_monitor_test
bind msdp_monitor msdp_chk chk (.*);
